// *** src/sbbu_core.sv ***
// Execution core for shift, bit manipulation and branch instructions.
// What this block does
// (RULE_01) Arithmetic shift left or right of byte, word or longword by one or two.
// (RULE_02) Logical shift left or right of byte, word or longword by one or two.
// (RULE_03) Rotate left or right by one or two, carry not in the loop.
// (RULE_04) Rotate left or right by one or two, carry as an extra bit.
// (RULE_05) Set a chosen bit of a byte; index from immediate or register bits 2:0.
// (RULE_06) Clear a chosen bit of a byte by immediate or register index.
// (RULE_07) Invert a chosen bit of a byte, other seven bits unchanged.
// (RULE_08) Test a chosen bit: zero flag gets its complement, operand kept.
// (RULE_09) Carry becomes carry AND the bit, or AND its complement.
// (RULE_10) Carry becomes carry OR the bit, or OR its complement.
// (RULE_11) Carry becomes carry XOR the bit, or XOR its complement.
// (RULE_12) Inverted bit forms take only the immediate index, never a register.
// (RULE_13) Carry gets the chosen bit, or its complement.
// (RULE_14) Chosen bit gets the carry, or its complement.
// (RULE_15) Conditional branch taken only when its simple condition holds.
// (RULE_16) Compound conditions: high, greater-or-equal, greater-than and complements.
// (RULE_17) Unconditional jump to the target with no flag test.
// (RULE_18) Subroutine call in relative-branch form and in jump form.
// (RULE_19) Return resumes at the instruction after the latest call.
// (RULE_20) A call stacks the return address; return reloads the counter from it.
// (RULE_21) Shifts load carry with the last bit out and set zero and negative.
`timescale 1ns/1ps

module sbbu_core (
	input wire logic clock,
	input wire logic reset,
	input wire logic op_valid,
	input wire sbbu_pkg::sbbu_op_t op_code,
	input wire sbbu_pkg::sbbu_size_t op_size,
	input wire logic [1:0] shift_count,
	input wire logic [31:0] operand_in,
	input wire logic bit_imm_sel,
	input wire logic [2:0] bit_imm,
	input wire logic [7:0] bit_reg,
	input wire sbbu_pkg::sbbu_cond_t branch_cond,
	input wire logic [15:0] branch_disp,
	input wire logic [31:0] jump_target,
	input wire logic [31:0] next_pc,
	input wire logic [31:0] stack_top,
	input wire logic flag_c_in,
	input wire logic flag_z_in,
	input wire logic flag_v_in,
	input wire logic flag_n_in,
	output logic done_q,
	output logic illegal_q,
	output logic [31:0] result_q,
	output logic result_we_q,
	output logic flag_c_q,
	output logic flag_z_q,
	output logic flag_v_q,
	output logic flag_n_q,
	output logic flag_c_we_q,
	output logic flag_z_we_q,
	output logic flag_v_we_q,
	output logic flag_n_we_q,
	output logic [31:0] pc_q,
	output logic pc_load_q,
	output logic [31:0] stack_ptr_q,
	output logic [31:0] stack_data_q,
	output logic stack_push_q,
	output logic stack_pop_q
);

	// ----------------------------------------------------------------
	// State of the unit
	// ----------------------------------------------------------------
	typedef struct packed {
		logic done;
		logic illegal;
		logic [31:0] result;
		logic result_we;
		logic fc;
		logic fz;
		logic fv;
		logic fn;
		logic fc_we;
		logic fz_we;
		logic fv_we;
		logic fn_we;
		logic [31:0] pc;
		logic pc_load;
		logic [31:0] sp;
		logic [31:0] stack_data;
		logic push;
		logic pop;
	} sbbu_state_t;

	sbbu_state_t s_q;
	sbbu_state_t s_d;

	// ----------------------------------------------------------------
	// Operand views shared by the datapath and its checks
	// ----------------------------------------------------------------
	logic [2:0] bit_idx;
	logic sel_bit;
	logic [7:0] bit_mask;
	logic inverted_form;
	logic cond_taken;
	logic [31:0] rel_target;
	logic [7:0] rotate_left_byte_chk;

	// The register index uses only its low three bits.
	assign bit_idx = bit_imm_sel ? bit_imm : bit_reg[2:0]; // [RULE_05]
	assign sel_bit = operand_in[bit_idx];
	assign bit_mask = 8'h01 << bit_idx;
	assign rel_target = next_pc + {{16{branch_disp[15]}}, branch_disp};
	assign rotate_left_byte_chk = {operand_in[6:0], operand_in[7]};

	// These forms carry no register index in their encoding.
	always_comb begin
		unique case (op_code)
			sbbu_pkg::SBBU_CARRY_AND_NOTBIT,
			sbbu_pkg::SBBU_CARRY_OR_NOTBIT,
			sbbu_pkg::SBBU_CARRY_XOR_NOTBIT,
			sbbu_pkg::SBBU_LOAD_NOTBIT_TO_CARRY,
			sbbu_pkg::SBBU_STORE_NOTCARRY_TO_BIT: inverted_form = 1'b1;
			default: inverted_form = 1'b0;
		endcase
	end

	// Flags of the condition code register as they stand now.
	sbbu_cond_eval u_cond (
		.cond(branch_cond),
		.flag_c(flag_c_in),
		.flag_z(flag_z_in),
		.flag_v(flag_v_in),
		.flag_n(flag_n_in),
		.taken(cond_taken)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// One instruction per cycle; strobes stand for one cycle as pulses, result values hold.
	always_comb begin
		logic [31:0] sv;
		logic [31:0] keep_mask;
		logic sc;
		logic msb_bit;
		int msb;
		sv = operand_in;
		keep_mask = 32'h0000_0000;
		sc = flag_c_in;
		msb_bit = 1'b0;
		msb = sbbu_pkg::LONG_MSB;
		s_d = s_q;
		s_d.done = op_valid;
		s_d.illegal = 1'b0;
		s_d.result_we = 1'b0;
		s_d.fc_we = 1'b0;
		s_d.fz_we = 1'b0;
		s_d.fv_we = 1'b0;
		s_d.fn_we = 1'b0;
		s_d.pc_load = 1'b0;
		s_d.push = 1'b0;
		s_d.pop = 1'b0;
		unique case (op_size)
			sbbu_pkg::SBBU_SZ_BYTE: msb = sbbu_pkg::BYTE_MSB;
			sbbu_pkg::SBBU_SZ_WORD: msb = sbbu_pkg::WORD_MSB;
			default: msb = sbbu_pkg::LONG_MSB;
		endcase
		// Bits above the operand size are held, as the register keeps them.
		keep_mask = ~((32'h0000_0002 << msb) - 32'h0000_0001);
		if (op_valid) begin
			unique case (op_code)
				sbbu_pkg::SBBU_ARITH_SHIFT_LEFT, sbbu_pkg::SBBU_ARITH_SHIFT_RIGHT,
				sbbu_pkg::SBBU_LOGIC_SHIFT_LEFT, sbbu_pkg::SBBU_LOGIC_SHIFT_RIGHT,
				sbbu_pkg::SBBU_ROTATE_LEFT, sbbu_pkg::SBBU_ROTATE_RIGHT,
				sbbu_pkg::SBBU_ROTATE_CARRY_LEFT, sbbu_pkg::SBBU_ROTATE_CARRY_RIGHT: begin
					// A count of two runs the one-place step twice.
					for (int k = 0; k < 2; k++) begin
						if ((k == 0) || (shift_count == sbbu_pkg::SHIFT_TWO)) begin
							msb_bit = sv[msb];
							if (!op_code[0]) begin
								sv = sv << 1; // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
								if (op_code == sbbu_pkg::SBBU_ROTATE_LEFT) begin
									sv[0] = msb_bit; // [RULE_03]
								end else if (op_code == sbbu_pkg::SBBU_ROTATE_CARRY_LEFT) begin
									sv[0] = sc; // [RULE_04]
								end
								sc = msb_bit; // [RULE_21]
							end else begin
								sc = sv[0]; // [RULE_21]
								sv = sv >> 1;
								unique case (op_code)
									sbbu_pkg::SBBU_ARITH_SHIFT_RIGHT: sv[msb] = msb_bit; // [RULE_01]
									sbbu_pkg::SBBU_LOGIC_SHIFT_RIGHT: sv[msb] = 1'b0; // [RULE_02]
									sbbu_pkg::SBBU_ROTATE_RIGHT: sv[msb] = sv[msb]; // [RULE_03]
									default: sv[msb] = sv[msb];
								endcase
								if (op_code == sbbu_pkg::SBBU_ROTATE_RIGHT) begin
									sv[msb] = operand_in[0] & (shift_count != sbbu_pkg::SHIFT_TWO)
										| ((k == 1) ? operand_in[1] : operand_in[0]); // [RULE_03]
								end else if (op_code == sbbu_pkg::SBBU_ROTATE_CARRY_RIGHT) begin
									sv[msb] = (k == 0) ? flag_c_in : operand_in[0]; // [RULE_04]
								end
							end
							sv = (sv & ~keep_mask) | (operand_in & keep_mask);
						end
					end
					s_d.result = sv; // [RULE_01] [RULE_02]
					s_d.result_we = 1'b1;
					s_d.fc = sc; // [RULE_21]
					s_d.fz = ((sv & ~keep_mask) == 32'h0000_0000); // [RULE_21]
					s_d.fn = sv[msb]; // [RULE_21]
					s_d.fv = 1'b0;
					s_d.fc_we = 1'b1;
					s_d.fz_we = 1'b1;
					s_d.fn_we = 1'b1;
					s_d.fv_we = 1'b1;
				end
				sbbu_pkg::SBBU_BIT_SET_OP: begin
					s_d.result = {operand_in[31:8], operand_in[7:0] | bit_mask}; // [RULE_05]
					s_d.result_we = 1'b1;
				end
				sbbu_pkg::SBBU_BIT_CLEAR_OP: begin
					s_d.result = {operand_in[31:8], operand_in[7:0] & ~bit_mask}; // [RULE_06]
					s_d.result_we = 1'b1;
				end
				sbbu_pkg::SBBU_BIT_INVERT_OP: begin
					s_d.result = {operand_in[31:8], operand_in[7:0] ^ bit_mask}; // [RULE_07]
					s_d.result_we = 1'b1;
				end
				sbbu_pkg::SBBU_BIT_TEST_OP: begin
					s_d.fz = ~sel_bit; // [RULE_08]
					s_d.fz_we = 1'b1;
				end
				sbbu_pkg::SBBU_CARRY_AND_BIT, sbbu_pkg::SBBU_CARRY_AND_NOTBIT,
				sbbu_pkg::SBBU_CARRY_OR_BIT, sbbu_pkg::SBBU_CARRY_OR_NOTBIT,
				sbbu_pkg::SBBU_CARRY_XOR_BIT, sbbu_pkg::SBBU_CARRY_XOR_NOTBIT,
				sbbu_pkg::SBBU_LOAD_BIT_TO_CARRY, sbbu_pkg::SBBU_LOAD_NOTBIT_TO_CARRY,
				sbbu_pkg::SBBU_STORE_CARRY_TO_BIT, sbbu_pkg::SBBU_STORE_NOTCARRY_TO_BIT: begin
					if (inverted_form && !bit_imm_sel) begin
						// A register index here is refused and nothing changes.
						s_d.illegal = 1'b1; // [RULE_12]
					end else begin
						unique case (op_code)
							sbbu_pkg::SBBU_CARRY_AND_BIT: s_d.fc = flag_c_in & sel_bit; // [RULE_09]
							sbbu_pkg::SBBU_CARRY_AND_NOTBIT: s_d.fc = flag_c_in & ~sel_bit; // [RULE_09]
							sbbu_pkg::SBBU_CARRY_OR_BIT: s_d.fc = flag_c_in | sel_bit; // [RULE_10]
							sbbu_pkg::SBBU_CARRY_OR_NOTBIT: s_d.fc = flag_c_in | ~sel_bit; // [RULE_10]
							sbbu_pkg::SBBU_CARRY_XOR_BIT: s_d.fc = flag_c_in ^ sel_bit; // [RULE_11]
							sbbu_pkg::SBBU_CARRY_XOR_NOTBIT: s_d.fc = flag_c_in ^ ~sel_bit; // [RULE_11]
							sbbu_pkg::SBBU_LOAD_BIT_TO_CARRY: s_d.fc = sel_bit; // [RULE_13]
							sbbu_pkg::SBBU_LOAD_NOTBIT_TO_CARRY: s_d.fc = ~sel_bit; // [RULE_13]
							default: s_d.fc = flag_c_in;
						endcase
						if (op_code == sbbu_pkg::SBBU_STORE_CARRY_TO_BIT) begin
							s_d.result = {operand_in[31:8],
								flag_c_in ? (operand_in[7:0] | bit_mask)
								: (operand_in[7:0] & ~bit_mask)}; // [RULE_14]
							s_d.result_we = 1'b1;
						end else if (op_code == sbbu_pkg::SBBU_STORE_NOTCARRY_TO_BIT) begin
							s_d.result = {operand_in[31:8],
								flag_c_in ? (operand_in[7:0] & ~bit_mask)
								: (operand_in[7:0] | bit_mask)}; // [RULE_14]
							s_d.result_we = 1'b1;
						end else begin
							s_d.fc_we = 1'b1;
						end
					end
				end
				sbbu_pkg::SBBU_BRANCH_COND: begin
					s_d.pc = rel_target;
					s_d.pc_load = cond_taken; // [RULE_15] [RULE_16]
				end
				sbbu_pkg::SBBU_JUMP_OP: begin
					s_d.pc = jump_target; // [RULE_17]
					s_d.pc_load = 1'b1;
				end
				sbbu_pkg::SBBU_BRANCH_SUBROUTINE, sbbu_pkg::SBBU_JUMP_SUBROUTINE: begin
					// The stack grows downward; the pointer names the last pushed word.
					s_d.pc = (op_code == sbbu_pkg::SBBU_BRANCH_SUBROUTINE)
						? rel_target : jump_target; // [RULE_18]
					s_d.pc_load = 1'b1;
					s_d.sp = s_q.sp - sbbu_pkg::STACK_STEP; // [RULE_20]
					s_d.stack_data = next_pc; // [RULE_20]
					s_d.push = 1'b1;
				end
				sbbu_pkg::SBBU_RETURN_SUBROUTINE: begin
					s_d.pc = stack_top; // [RULE_19] [RULE_20]
					s_d.pc_load = 1'b1;
					s_d.sp = s_q.sp + sbbu_pkg::STACK_STEP; // [RULE_20]
					s_d.pop = 1'b1;
				end
				default: s_d.illegal = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Synchronous reset; the stack pointer starts at its top.
	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.pc <= sbbu_pkg::PC_RESET;
			s_q.sp <= sbbu_pkg::SP_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	// Every output is a field of the state register.
	assign done_q = s_q.done;
	assign illegal_q = s_q.illegal;
	assign result_q = s_q.result;
	assign result_we_q = s_q.result_we;
	assign flag_c_q = s_q.fc;
	assign flag_z_q = s_q.fz;
	assign flag_v_q = s_q.fv;
	assign flag_n_q = s_q.fn;
	assign flag_c_we_q = s_q.fc_we;
	assign flag_z_we_q = s_q.fz_we;
	assign flag_v_we_q = s_q.fv_we;
	assign flag_n_we_q = s_q.fn_we;
	assign pc_q = s_q.pc;
	assign pc_load_q = s_q.pc_load;
	assign stack_ptr_q = s_q.sp;
	assign stack_data_q = s_q.stack_data;
	assign stack_push_q = s_q.push;
	assign stack_pop_q = s_q.pop;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_rotate_left_byte;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_ROTATE_LEFT && op_size == sbbu_pkg::SBBU_SZ_BYTE
			&& shift_count == sbbu_pkg::SHIFT_ONE
		|=> result_we_q && result_q[7:0] == $past(rotate_left_byte_chk) && flag_c_q == result_q[0];
	endproperty
	a_rotate_left_byte: assert property (p_rotate_left_byte) else $error("byte rotate left wrong"); // [RULE_03]

	property p_bit_set;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_BIT_SET_OP
		|=> result_we_q && result_q[7:0] == ($past(operand_in[7:0]) | $past(bit_mask));
	endproperty
	a_bit_set: assert property (p_bit_set) else $error("bit set result wrong"); // [RULE_05]

	property p_bit_test;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_BIT_TEST_OP
		|=> flag_z_we_q && flag_z_q == !$past(sel_bit) && !result_we_q && !flag_c_we_q;
	endproperty
	a_bit_test: assert property (p_bit_test) else $error("bit test flag wrong"); // [RULE_08]

	property p_refuse_reg_index;
		@(posedge clock) disable iff (reset)
		op_valid && inverted_form && !bit_imm_sel
		|=> illegal_q && !result_we_q && !flag_c_we_q && !pc_load_q;
	endproperty
	a_refuse_reg_index: assert property (p_refuse_reg_index) // [RULE_12]
		else $error("register index taken");

	property p_load_carry;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_LOAD_NOTBIT_TO_CARRY && bit_imm_sel
		|=> flag_c_we_q && flag_c_q != $past(sel_bit);
	endproperty
	a_load_carry: assert property (p_load_carry) else $error("carry load wrong"); // [RULE_13]

	property p_branch_never;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_BRANCH_COND && branch_cond == sbbu_pkg::SBBU_CC_NEVER
		|=> !pc_load_q ##1 1'b1;
	endproperty
	a_branch_never: assert property (p_branch_never) else $error("never branch taken"); // [RULE_15]

	property p_branch_high;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_BRANCH_COND && branch_cond == sbbu_pkg::SBBU_CC_HIGH
		|=> pc_load_q == !($past(flag_c_in) || $past(flag_z_in));
	endproperty
	a_branch_high: assert property (p_branch_high) else $error("high condition wrong"); // [RULE_16]

	property p_jump;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_JUMP_OP
		|=> pc_load_q && pc_q == $past(jump_target) && !stack_push_q;
	endproperty
	a_jump: assert property (p_jump) else $error("jump target wrong"); // [RULE_17]

	property p_call_push;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_JUMP_SUBROUTINE
		|=> stack_push_q && stack_data_q == $past(next_pc)
			&& stack_ptr_q == $past(stack_ptr_q) - sbbu_pkg::STACK_STEP;
	endproperty
	a_call_push: assert property (p_call_push) else $error("call did not stack return"); // [RULE_20]

	property p_return;
		@(posedge clock) disable iff (reset)
		op_valid && op_code == sbbu_pkg::SBBU_RETURN_SUBROUTINE
		|=> pc_load_q && stack_pop_q && pc_q == $past(stack_top);
	endproperty
	a_return: assert property (p_return) else $error("return address wrong"); // [RULE_19]

endmodule // sbbu_core

// *** include/sbbu_pkg.sv ***
// Shared constants and types of the shift, bit and branch execution unit.
package sbbu_pkg;

	// ----------------------------------------------------------------
	// Widths and reset values
	// ----------------------------------------------------------------
	localparam int DATA_W = 32;
	localparam int BYTE_MSB = 7;
	localparam int WORD_MSB = 15;
	localparam int LONG_MSB = 31;
	localparam logic [31:0] PC_RESET = 32'h0000_0000;
	localparam logic [31:0] SP_RESET = 32'h0000_fff0;
	// Each stacked return address takes one longword.
	localparam logic [31:0] STACK_STEP = 32'h0000_0004;
	// Shifts and rotations move the operand by one or by two places.
	localparam logic [1:0] SHIFT_ONE = 2'h1;
	localparam logic [1:0] SHIFT_TWO = 2'h2;

	// ----------------------------------------------------------------
	// Operand size
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SBBU_SZ_BYTE = 2'h0,
		SBBU_SZ_WORD = 2'h1,
		SBBU_SZ_LONG = 2'h2
	} sbbu_size_t;

	// ----------------------------------------------------------------
	// Operations carried out by the unit
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		SBBU_ARITH_SHIFT_LEFT = 5'h00,
		SBBU_ARITH_SHIFT_RIGHT = 5'h01,
		SBBU_LOGIC_SHIFT_LEFT = 5'h02,
		SBBU_LOGIC_SHIFT_RIGHT = 5'h03,
		SBBU_ROTATE_LEFT = 5'h04,
		SBBU_ROTATE_RIGHT = 5'h05,
		SBBU_ROTATE_CARRY_LEFT = 5'h06,
		SBBU_ROTATE_CARRY_RIGHT = 5'h07,
		SBBU_BIT_SET_OP = 5'h08,
		SBBU_BIT_CLEAR_OP = 5'h09,
		SBBU_BIT_INVERT_OP = 5'h0a,
		SBBU_BIT_TEST_OP = 5'h0b,
		SBBU_CARRY_AND_BIT = 5'h0c,
		SBBU_CARRY_AND_NOTBIT = 5'h0d,
		SBBU_CARRY_OR_BIT = 5'h0e,
		SBBU_CARRY_OR_NOTBIT = 5'h0f,
		SBBU_CARRY_XOR_BIT = 5'h10,
		SBBU_CARRY_XOR_NOTBIT = 5'h11,
		SBBU_LOAD_BIT_TO_CARRY = 5'h12,
		SBBU_LOAD_NOTBIT_TO_CARRY = 5'h13,
		SBBU_STORE_CARRY_TO_BIT = 5'h14,
		SBBU_STORE_NOTCARRY_TO_BIT = 5'h15,
		SBBU_BRANCH_COND = 5'h16,
		SBBU_JUMP_OP = 5'h17,
		SBBU_BRANCH_SUBROUTINE = 5'h18,
		SBBU_JUMP_SUBROUTINE = 5'h19,
		SBBU_RETURN_SUBROUTINE = 5'h1a
	} sbbu_op_t;

	// ----------------------------------------------------------------
	// Branch conditions
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		SBBU_CC_ALWAYS = 4'h0,
		SBBU_CC_NEVER = 4'h1,
		SBBU_CC_HIGH = 4'h2,
		SBBU_CC_LOW_SAME = 4'h3,
		SBBU_CC_CARRY_CLEAR = 4'h4,
		SBBU_CC_CARRY_SET = 4'h5,
		SBBU_CC_NOT_EQUAL = 4'h6,
		SBBU_CC_EQUAL = 4'h7,
		SBBU_CC_OVF_CLEAR = 4'h8,
		SBBU_CC_OVF_SET = 4'h9,
		SBBU_CC_PLUS = 4'ha,
		SBBU_CC_MINUS = 4'hb,
		SBBU_CC_GREATER_EQ = 4'hc,
		SBBU_CC_LESS = 4'hd,
		SBBU_CC_GREATER = 4'he,
		SBBU_CC_LESS_EQ = 4'hf
	} sbbu_cond_t;

endpackage

// *** src/sbbu_cond_eval.sv ***
// Branch condition evaluator for the shift, bit and branch execution unit.
`timescale 1ns/1ps

module sbbu_cond_eval (
	input wire sbbu_pkg::sbbu_cond_t cond,
	input wire logic flag_c,
	input wire logic flag_z,
	input wire logic flag_v,
	input wire logic flag_n,
	output logic taken
);

	// ----------------------------------------------------------------
	// Condition decode
	// ----------------------------------------------------------------
	logic low_same;
	logic sign_diff;
	logic less_eq;

	// The compound terms feed a true form and its complement.
	assign low_same = flag_c | flag_z; // [RULE_16]
	assign sign_diff = flag_n ^ flag_v; // [RULE_16]
	assign less_eq = flag_z | sign_diff; // [RULE_16]

	// Each pair of codes differs only in the sense of its flag test.
	always_comb begin
		unique case (cond)
			sbbu_pkg::SBBU_CC_ALWAYS: taken = 1'b1; // [RULE_15]
			sbbu_pkg::SBBU_CC_NEVER: taken = 1'b0; // [RULE_15]
			sbbu_pkg::SBBU_CC_HIGH: taken = ~low_same; // [RULE_16]
			sbbu_pkg::SBBU_CC_LOW_SAME: taken = low_same; // [RULE_16]
			sbbu_pkg::SBBU_CC_CARRY_CLEAR: taken = ~flag_c; // [RULE_15]
			sbbu_pkg::SBBU_CC_CARRY_SET: taken = flag_c; // [RULE_15]
			sbbu_pkg::SBBU_CC_NOT_EQUAL: taken = ~flag_z; // [RULE_15]
			sbbu_pkg::SBBU_CC_EQUAL: taken = flag_z; // [RULE_15]
			sbbu_pkg::SBBU_CC_OVF_CLEAR: taken = ~flag_v; // [RULE_15]
			sbbu_pkg::SBBU_CC_OVF_SET: taken = flag_v; // [RULE_15]
			sbbu_pkg::SBBU_CC_PLUS: taken = ~flag_n; // [RULE_15]
			sbbu_pkg::SBBU_CC_MINUS: taken = flag_n; // [RULE_15]
			sbbu_pkg::SBBU_CC_GREATER_EQ: taken = ~sign_diff; // [RULE_16]
			sbbu_pkg::SBBU_CC_LESS: taken = sign_diff; // [RULE_16]
			sbbu_pkg::SBBU_CC_GREATER: taken = ~less_eq; // [RULE_16]
			sbbu_pkg::SBBU_CC_LESS_EQ: taken = less_eq; // [RULE_16]
		endcase
	end

endmodule // sbbu_cond_eval

// *** bench/tb_top.sv ***
// Self-checking testbench of the shift, bit and branch execution unit.
`timescale 1ns/1ps

module tb_top;
	// ----------------------------------------------------------------
	// Stimulus, expectations and reference model
	// ----------------------------------------------------------------
	typedef struct packed {
		logic v;
		sbbu_pkg::sbbu_op_t op;
		sbbu_pkg::sbbu_size_t sz;
		sbbu_pkg::sbbu_cond_t cc;
		logic [1:0] cnt;
		logic sel;
		logic [2:0] imm;
		logic [7:0] breg;
		logic [15:0] disp;
		logic [31:0] x, tgt, npc, stk;
		logic c, z, vf, n;
	} sbbu_stim_t;
	// Control bits: illegal, result, c, z, n, v writes, pc load, push, pop.
	typedef struct packed {
		logic [8:0] ctl;
		logic [31:0] res;
		logic [3:0] fl;
		logic [31:0] pc, sp, sd;
	} sbbu_exp_t;
	logic clock = 1'b0;
	logic reset = 1'b1;
	sbbu_stim_t a = '0;
	sbbu_stim_t d = '0;
	sbbu_exp_t q[$];
	sbbu_exp_t e;
	logic [31:0] sp_exp = sbbu_pkg::SP_RESET;
	logic [31:0] n1, n2;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic done_q, illegal_q, result_we_q, pc_load_q, stack_push_q, stack_pop_q;
	logic flag_c_q, flag_z_q, flag_v_q, flag_n_q;
	logic flag_c_we_q, flag_z_we_q, flag_v_we_q, flag_n_we_q;
	logic [31:0] result_q, pc_q, stack_ptr_q, stack_data_q;

	// The model sees only the stimulus, so a design slip cannot leak into its answer.
	function automatic sbbu_exp_t model(input sbbu_stim_t s);
		sbbu_exp_t r;
		logic [31:0] x, mk, sx;
		logic [7:0] tv;
		logic [2:0] idx;
		logic c, o, nb, f;
		int m;
		r = '0;
		x = s.x;
		c = s.c;
		m = (s.sz == sbbu_pkg::SBBU_SZ_BYTE) ? 7 : (s.sz == sbbu_pkg::SBBU_SZ_WORD) ? 15 : 31;
		mk = 32'hffff_ffff >> (31 - m);
		sx = s.npc + {{16{s.disp[15]}}, s.disp};
		idx = s.sel ? s.imm : s.breg[2:0];
		nb = x[idx] ^ s.op[0];
		tv = {~(s.z | (s.n ^ s.vf)), ~(s.n ^ s.vf), ~s.n, ~s.vf, ~s.z, ~s.c, ~(s.c | s.z), 1'b1};
		r.sp = sp_exp;
		r.sd = s.npc;
		r.pc = (s.op == 5'h17 || s.op == 5'h19) ? s.tgt : (s.op == 5'h1a) ? s.stk : sx;
		if (s.op < 5'h08) begin
			for (int i = 0; i < ((s.cnt == 2'h2) ? 2 : 1); i++) begin
				o = s.op[0] ? x[0] : x[m];
				f = (s.op[2:1] == 2'h2) ? o : (s.op[2:1] == 2'h3) ? c : (s.op == 5'h01) && x[m];
				x = s.op[0] ? ((x & ~mk) | ((x & mk) >> 1)) : ((x & ~mk) | ((x << 1) & mk));
				x[s.op[0] ? m : 0] = f;
				c = o;
			end
			r.ctl = 9'h0f8;
			r.res = x;
			r.fl = {c, (x & mk) == 32'h0, x[m], 1'b0};
		end else if (s.op < 5'h16) begin
			if (s.op >= 5'h0c && s.op[0] && !s.sel) begin
				r.ctl = 9'h100;
			end else if (s.op < 5'h0b || s.op >= 5'h14) begin
				x[idx] = (s.op == 5'h08) | ((s.op >= 5'h14) & (c ^ s.op[0])) | ((s.op == 5'h0a) & ~nb);
				r.ctl = 9'h080;
				r.res = x;
			end else if (s.op == 5'h0b) begin
				r.ctl = 9'h020;
				r.fl = {1'b0, nb, 2'h0};
			end else begin
				r.ctl = 9'h040;
				r.fl = {(s.op[4:1] == 4'h6) ? c & nb : (s.op[4:1] == 4'h7) ? c | nb :
					(s.op[4:1] == 4'h8) ? c ^ nb : nb, 3'h0};
			end
		end else begin
			case (5'(s.op))
				5'h16: r.ctl = {6'h0, tv[s.cc[3:1]] ^ s.cc[0], 2'h0};
				5'h17: r.ctl = 9'h004;
				5'h18, 5'h19: r = '{9'h006, 32'h0, 4'h0, r.pc, sp_exp - sbbu_pkg::STACK_STEP, r.sd};
				5'h1a: r = '{9'h005, 32'h0, 4'h0, r.pc, sp_exp + sbbu_pkg::STACK_STEP, r.sd};
				default: r.ctl = 9'h100;
			endcase
		end
		return r;
	endfunction

	// One instruction per call; back-to-back calls keep the valid strobe up.
	task automatic go(input sbbu_pkg::sbbu_op_t op);
		a.op = op;
		a.v = 1'b1;
		q.push_back(model(a));
		sp_exp = q[$].sp;
		@(posedge clock);
		d <= a;
	endtask

	task automatic idle(input string name);
		@(posedge clock);
		d.v <= 1'b0;
		$display("test %s done", name);
	endtask

	always #25 clock = ~clock;

	sbbu_core DUT (.clock(clock), .reset(reset), .op_valid(d.v), .op_code(d.op), .op_size(d.sz),
		.shift_count(d.cnt), .operand_in(d.x), .bit_imm_sel(d.sel), .bit_imm(d.imm),
		.bit_reg(d.breg), .branch_cond(d.cc), .branch_disp(d.disp), .jump_target(d.tgt),
		.next_pc(d.npc), .stack_top(d.stk), .flag_c_in(d.c), .flag_z_in(d.z), .flag_v_in(d.vf),
		.flag_n_in(d.n), .done_q(done_q), .illegal_q(illegal_q), .result_q(result_q),
		.result_we_q(result_we_q), .flag_c_q(flag_c_q), .flag_z_q(flag_z_q), .flag_v_q(flag_v_q),
		.flag_n_q(flag_n_q), .flag_c_we_q(flag_c_we_q), .flag_z_we_q(flag_z_we_q),
		.flag_v_we_q(flag_v_we_q), .flag_n_we_q(flag_n_we_q), .pc_q(pc_q), .pc_load_q(pc_load_q),
		.stack_ptr_q(stack_ptr_q), .stack_data_q(stack_data_q), .stack_push_q(stack_push_q),
		.stack_pop_q(stack_pop_q));

	// ----------------------------------------------------------------
	// Checking
	// ----------------------------------------------------------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Sampling on the falling edge keeps the monitor clear of the launch edge.
	always @(negedge clock) begin
		if (done_q === 1'b1) begin
			e = q.pop_front();
			cmp(32'({illegal_q, result_we_q, flag_c_we_q, flag_z_we_q, flag_n_we_q, flag_v_we_q,
				pc_load_q, stack_push_q, stack_pop_q}), 32'(e.ctl));
			if (e.ctl[7]) cmp(result_q, e.res);
			cmp(32'({flag_c_q, flag_z_q, flag_n_q, flag_v_q} & e.ctl[6:3]), 32'(e.fl));
			if (e.ctl[2]) cmp(pc_q, e.pc);
			cmp(stack_ptr_q, e.sp);
			if (e.ctl[1]) cmp(stack_data_q, e.sd);
		end
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// A hung run is cut short well beyond the few hundred cycles the tests need.
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			end_sim();
		end
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'hfc13));
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(negedge clock);
		cmp(stack_ptr_q, sbbu_pkg::SP_RESET);
		cmp(pc_q, sbbu_pkg::PC_RESET);
		cmp(32'(done_q), 32'h0);
		for (int o = 0; o < 22; o++) begin
			for (int k = 0; k < 6; k++) begin
				a.sz = sbbu_pkg::sbbu_size_t'(k % 3);
				a.cnt = (k < 3) ? sbbu_pkg::SHIFT_ONE : sbbu_pkg::SHIFT_TWO;
				{a.x, a.c, a.sel, a.imm, a.breg} = {$urandom(), k[0], 12'($urandom())};
				go(sbbu_pkg::sbbu_op_t'(o));
			end
		end
		idle("shift and bit");
		for (int k = 0; k < 64; k++) begin
			{a.c, a.z, a.vf, a.n, a.disp, a.npc} = {4'($urandom()), 16'($urandom()), $urandom()};
			a.cc = sbbu_pkg::sbbu_cond_t'(k % 16);
			go(sbbu_pkg::SBBU_BRANCH_COND);
		end
		idle("branch");
		{a.tgt, a.npc} = {$urandom(), $urandom()};
		go(sbbu_pkg::SBBU_JUMP_OP);
		n1 = a.npc;
		go(sbbu_pkg::SBBU_JUMP_SUBROUTINE);
		{a.disp, a.npc} = {16'h8000, $urandom()};
		n2 = a.npc;
		go(sbbu_pkg::SBBU_BRANCH_SUBROUTINE);
		a.stk = n2;
		go(sbbu_pkg::SBBU_RETURN_SUBROUTINE);
		a.stk = n1;
		go(sbbu_pkg::SBBU_RETURN_SUBROUTINE);
		go(sbbu_pkg::sbbu_op_t'(5'h1b));
		idle("call and return");
		repeat (3) @(posedge clock);
		cmp(32'(q.size()), 32'h0);
		end_sim();
	end
endmodule // tb_top
